// ===== hdl/ebu_pkg.sv
// Constants, carrier types and states of the external bus unit.
// Assumes one system clock domain; all pins are sampled or driven by the top module.
//
// Functional notes
// - Single-chip mode or one of four modes: 8/16-bit data, multiplexed or not.
// - Demultiplexed: address on dedicated lines, data on shared lines or their low byte.
// - Multiplexed: shared lines carry address first, then data.
// - Segment lines drive upper address; active line count selectable, 0 to 8.
// - Five chip selects: one per window plus one default select.
// - Ready input extends slow accesses; its active level is programmable.
// - Arbitration off until enabled; then claim, grant and request pins run automatically.
// - Master after reset drives grant pin; slave turns it into an input.
// - Bus timing programmable per chip-select region by timing and function settings.
// - Four address windows, each with its own bus characteristics.
// - Overlap: window four beats three, window two beats one.
// - Addresses outside all windows use the default region settings.
// - The selecting window asserts its chip select for the access.
// - Bus timing follows the rising edge of the reference clock output.
// - Bus mode switches per access according to the selected window.
// - Internal peripheral bus accesses run in single-chip mode too and drive no bus pins.
package ebu_pkg;
  localparam int AW = 24;
  localparam int DW = 16;
  localparam int NWIN = 4;
  localparam int NREG = 5;
  localparam int SEGW = 8;
  localparam int WTAGW = 12;
  localparam int LOW_AW = 16;
  // Bus modes
  localparam logic [1:0] MODE_DMX16 = 2'h0;
  localparam logic [1:0] MODE_MUX16 = 2'h1;
  localparam logic [1:0] MODE_MUX8 = 2'h2;
  localparam logic [1:0] MODE_DMX8 = 2'h3;
  // Internal peripheral bus range: address bits 23..11 equal to this tag
  localparam int LXB_LSB = 11;
  localparam logic [12:0] LXB_TAG = 13'h0400;
  localparam logic [7:0] SEG_ALL = 8'hff;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [3:0] CNT_ZERO = 4'h0;

  typedef struct packed {
    logic [1:0] mode;
    logic rdy_en;
    logic rdy_pol;
    logic cs_en;
    logic [1:0] addr_cyc;
    logic [3:0] wait_cyc;
  } ebu_rcfg_t;

  typedef struct packed {
    logic en;
    logic [WTAGW-1:0] base;
    logic [WTAGW-1:0] mask;
  } ebu_wcfg_t;

  typedef struct packed {
    logic req;
    logic we;
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
  } ebu_req_t;

  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_ADDR = 5'b00010,
    ST_DATA = 5'b00100,
    ST_DONE = 5'b01000,
    ST_HOLD = 5'b10000
  } ebu_state_t;
endpackage : ebu_pkg

// ===== hdl/ebu_top.sv
// External bus unit: window decode, bus sequencing, pin drive and arbitration.
// Assumes a CPU-side request held until acknowledged, and asynchronous bus pins.
`timescale 1ns/1ps
module ebu_top (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input ebu_pkg::ebu_req_t req_i,
  output logic ack_o,
  output logic err_o,
  output logic [ebu_pkg::DW-1:0] rdata_o,
  input wire logic ext_en_i,
  input wire logic [3:0] seg_cnt_i,
  input ebu_pkg::ebu_wcfg_t win_cfg_i [ebu_pkg::NWIN],
  input ebu_pkg::ebu_rcfg_t reg_cfg_i [ebu_pkg::NREG],
  input wire logic arb_en_i,
  input wire logic slave_i,
  output logic reference_clock_output_o,
  output logic bus_oe_o,
  output logic [ebu_pkg::LOW_AW-1:0] addr_o,
  output logic [ebu_pkg::SEGW-1:0] seg_o,
  output logic [ebu_pkg::DW-1:0] ad_o,
  output logic [ebu_pkg::DW-1:0] ad_oe_o,
  input wire logic [ebu_pkg::DW-1:0] ad_i,
  output logic [ebu_pkg::NREG-1:0] cs_n_o,
  output logic ale_o,
  output logic rd_n_o,
  output logic wr_n_o,
  input wire logic ready_i,
  input wire logic hold_n_i,
  output logic bus_claim_out_n_o,
  output logic grant_acknowledge_n_o,
  output logic grant_acknowledge_oe_o,
  input wire logic grant_acknowledge_n_i,
  output ebu_pkg::ebu_req_t lx_req_o,
  input wire logic [ebu_pkg::DW-1:0] lx_rdata_i,
  input wire logic lx_ready_i
);
  import ebu_pkg::*;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  localparam int SYW = DW + 3;
  logic [SYW-1:0] sy1_reg;
  logic [SYW-1:0] sy2_reg;
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sy1_reg <= '1;
      sy2_reg <= '1;
    end else begin
      sy1_reg <= {ready_i, hold_n_i, grant_acknowledge_n_i, ad_i};
      sy2_reg <= sy1_reg;
    end
  end
  wire ready_s = sy2_reg[DW+2];
  wire hold_n_s = sy2_reg[DW+1];
  wire grant_acknowledge_n_s = sy2_reg[DW];
  wire [DW-1:0] ad_s = sy2_reg[DW-1:0];

  // ----------------------------------------------------------------
  // Reference clock and bus tick
  // ----------------------------------------------------------------
  logic clk_reg;
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      clk_reg <= 1'b0;
    end else begin
      clk_reg <= ~clk_reg;
    end
  end
  // State moves only in the cycle the reference clock rises
  wire tick = ~clk_reg;

  // ----------------------------------------------------------------
  // Window decode
  // ----------------------------------------------------------------
  logic [NWIN-1:0] hit;
  for (genvar w = 0; w < NWIN; w++) begin : g_win
    assign hit[w] = win_cfg_i[w].en &&
      ((req_i.addr[AW-1:AW-WTAGW] & win_cfg_i[w].mask) ==
       (win_cfg_i[w].base & win_cfg_i[w].mask));
  end
  // Region 0 is the default; regions 1..4 follow the windows
  wire [2:0] sel = hit[3] ? 3'h4 : hit[2] ? 3'h3 :
                   hit[1] ? 3'h2 : hit[0] ? 3'h1 : 3'h0;
  wire ebu_rcfg_t sel_cfg = reg_cfg_i[sel];
  wire is_lx = req_i.addr[AW-1:LXB_LSB] == LXB_TAG;

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  ebu_state_t st_reg;
  ebu_rcfg_t cfg_reg;
  logic [2:0] sel_reg;
  logic lx_reg;
  logic we_reg;
  logic [AW-1:0] a_reg;
  logic [DW-1:0] wd_reg;
  logic [3:0] cnt_reg;
  logic ack_reg;

  wire take = req_i.req && !ack_reg;
  wire hold_rq = arb_en_i && !slave_i && !hold_n_s;
  wire granted = !(arb_en_i && slave_i) || !grant_acknowledge_n_s;
  wire is8 = cfg_reg.mode == MODE_MUX8 || cfg_reg.mode == MODE_DMX8;
  wire ismux = cfg_reg.mode == MODE_MUX16 || cfg_reg.mode == MODE_MUX8;
  wire rdy_ok = lx_reg ? lx_ready_i :
                (!cfg_reg.rdy_en || ready_s == cfg_reg.rdy_pol);
  wire data_end = cnt_reg == CNT_ZERO && rdy_ok;
  wire [DW-1:0] rd_val = lx_reg ? lx_rdata_i :
                         is8 ? {BYTE_ZERO, ad_s[7:0]} : ad_s;

  wire in_idle = tick && st_reg == ST_IDLE;
  wire refuse = in_idle && !hold_rq && take && !is_lx && !ext_en_i;
  wire start = in_idle && !hold_rq && !refuse && take && (is_lx || granted);
  wire fin = tick && st_reg == ST_DATA && data_end;

  // ----------------------------------------------------------------
  // Request capture
  // ----------------------------------------------------------------
  // Address, data and region settings stay fixed for the whole access
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cfg_reg <= '0;
      sel_reg <= 3'h0;
      lx_reg <= 1'b0;
      we_reg <= 1'b0;
      a_reg <= '0;
      wd_reg <= '0;
    end else if (start) begin
      cfg_reg <= sel_cfg;
      sel_reg <= sel;
      lx_reg <= is_lx;
      we_reg <= req_i.we;
      a_reg <= req_i.addr;
      wd_reg <= req_i.wdata;
    end
  end

  // ----------------------------------------------------------------
  // Completion pulses and read data
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ack_reg <= 1'b0;
      err_o <= 1'b0;
      rdata_o <= '0;
    end else begin
      ack_reg <= refuse || fin;
      err_o <= refuse;
      if (fin && !we_reg) begin
        rdata_o <= rd_val;
      end
    end
  end

  // ----------------------------------------------------------------
  // State and phase counter
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_reg <= ST_IDLE;
      cnt_reg <= CNT_ZERO;
    end else if (tick) begin
      case (st_reg)
        ST_IDLE: begin
          if (hold_rq) begin
            st_reg <= ST_HOLD;
          end else if (start) begin
            st_reg <= ST_ADDR;
            cnt_reg <= {2'h0, sel_cfg.addr_cyc};
          end
        end
        ST_ADDR: begin
          if (cnt_reg == CNT_ZERO) begin
            st_reg <= ST_DATA;
            cnt_reg <= cfg_reg.wait_cyc;
          end else begin
            cnt_reg <= cnt_reg - 4'h1;
          end
        end
        ST_DATA: begin
          if (cnt_reg != CNT_ZERO) begin
            cnt_reg <= cnt_reg - 4'h1;
          end else if (rdy_ok) begin
            st_reg <= ST_DONE;
          end
        end
        ST_DONE: begin
          st_reg <= ST_IDLE;
        end
        ST_HOLD: begin
          if (hold_n_s) begin
            st_reg <= ST_IDLE;
          end
        end
        default: begin
          st_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Pin drive
  // ----------------------------------------------------------------
  wire ext_now = (st_reg == ST_ADDR || st_reg == ST_DATA) && !lx_reg;
  wire in_addr = st_reg == ST_ADDR;
  wire in_data = st_reg == ST_DATA;
  wire [SEGW-1:0] seg_mask = ~(SEG_ALL << seg_cnt_i);
  wire [DW-1:0] dat_mask = is8 ? {BYTE_ZERO, SEG_ALL} : '1;
  wire [DW-1:0] ad_nx = (ismux && in_addr) ? a_reg[LOW_AW-1:0] :
                        is8 ? {BYTE_ZERO, wd_reg[7:0]} : wd_reg;
  wire [DW-1:0] oe_nx = !ext_now ? '0 :
                        (ismux && in_addr) ? '1 :
                        (in_data && we_reg) ? dat_mask : '0;
  logic [NREG-1:0] cs_nx;
  for (genvar r = 0; r < NREG; r++) begin : g_cs
    assign cs_nx[r] = !(ext_now && sel_reg == 3'(r) && cfg_reg.cs_en);
  end
  // A slave keeps its claim up until its access ends, and drives only while granted
  wire want_bus = arb_en_i && slave_i &&
                  ((st_reg == ST_IDLE && take && !is_lx && ext_en_i) || ext_now);
  wire bus_own = st_reg != ST_HOLD && granted;

  // ----------------------------------------------------------------
  // Reference clock and handshake outputs
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      reference_clock_output_o <= 1'b0;
      ack_o <= 1'b0;
      bus_oe_o <= 1'b0;
    end else begin
      reference_clock_output_o <= clk_reg;
      ack_o <= ack_reg;
      bus_oe_o <= bus_own && ext_en_i;
    end
  end

  // ----------------------------------------------------------------
  // Address, segment and shared lines
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      addr_o <= '0;
      seg_o <= '0;
      ad_o <= '0;
      ad_oe_o <= '0;
    end else begin
      addr_o <= ext_now ? a_reg[LOW_AW-1:0] : '0;
      seg_o <= ext_now ? (a_reg[AW-1:LOW_AW] & seg_mask) : '0;
      ad_o <= ad_nx;
      ad_oe_o <= oe_nx;
    end
  end

  // ----------------------------------------------------------------
  // Selects and strobes
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cs_n_o <= '1;
      ale_o <= 1'b0;
      rd_n_o <= 1'b1;
      wr_n_o <= 1'b1;
    end else begin
      cs_n_o <= cs_nx;
      ale_o <= ext_now && in_addr;
      rd_n_o <= !(ext_now && in_data && !we_reg);
      wr_n_o <= !(ext_now && in_data && we_reg);
    end
  end

  // ----------------------------------------------------------------
  // Arbitration pins
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bus_claim_out_n_o <= 1'b1;
      grant_acknowledge_n_o <= 1'b1;
      grant_acknowledge_oe_o <= 1'b1;
    end else begin
      bus_claim_out_n_o <= !want_bus;
      grant_acknowledge_n_o <= !(st_reg == ST_HOLD);
      grant_acknowledge_oe_o <= !(arb_en_i && slave_i);
    end
  end

  // ----------------------------------------------------------------
  // Internal peripheral bus
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lx_req_o <= '0;
    end else begin
      lx_req_o.req <= lx_reg && in_data;
      lx_req_o.we <= we_reg;
      lx_req_o.addr <= a_reg;
      lx_req_o.wdata <= wd_reg;
    end
  end
endmodule : ebu_top

// ===== test/ebu_asserts.sv
// Concurrent checks on the external bus unit pins.
// Assumes binding to ebu_top; sees only its ports.
`timescale 1ns/1ps
module ebu_asserts (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic ack_o,
  input wire logic err_o,
  input wire logic [3:0] seg_cnt_i,
  input wire logic arb_en_i,
  input wire logic slave_i,
  input wire logic reference_clock_output_o,
  input wire logic bus_oe_o,
  input wire logic [7:0] seg_o,
  input wire logic [15:0] ad_oe_o,
  input wire logic [4:0] cs_n_o,
  input wire logic ale_o,
  input wire logic rd_n_o,
  input wire logic wr_n_o,
  input wire logic bus_claim_out_n_o,
  input wire logic grant_acknowledge_n_o,
  input wire logic grant_acknowledge_oe_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  err_ack_a: assert property (err_o |=> ack_o && !err_o) else $error("no ack after err");
  strobe_one_a: assert property (rd_n_o || wr_n_o) else $error("both strobes low");
  ale_strobe_a: assert property (ale_o |-> rd_n_o && wr_n_o) else $error("ale in data");
  seg_mask_a: assert property (seg_cnt_i <= 4'h8 |-> (16'(seg_o) >> seg_cnt_i) == 16'h0)
    else $error("segment line above count");
  cs_onehot_a: assert property ($onehot0(~cs_n_o)) else $error("two selects low");
  strobe_edge_a: assert property ($fell(rd_n_o) || $fell(wr_n_o) || $rose(ale_o) |->
    $rose(reference_clock_output_o)) else $error("strobe off clock edge");
  arb_off_a: assert property (!arb_en_i [*2] |-> grant_acknowledge_n_o && bus_claim_out_n_o)
    else $error("arbitration pin active");
  master_pin_a: assert property (!slave_i [*3] |-> grant_acknowledge_oe_o) else $error("master pin");
  slave_pin_a: assert property ((arb_en_i && slave_i) [*3] |-> !grant_acknowledge_oe_o)
    else $error("slave pin");
  hold_free_a: assert property (!grant_acknowledge_n_o && grant_acknowledge_oe_o && !$past(grant_acknowledge_n_o) |->
    !bus_oe_o && ad_oe_o == 16'h0) else $error("bus held in hold");
endmodule : ebu_asserts

// ===== test/ebu_mem_model.sv
// External memory with a programmable ready delay and polarity.
// Assumes strobes and address latch from the bus unit pins.
`timescale 1ns/1ps
module ebu_mem_model (
  input wire logic clk_i,
  input wire logic ale_i,
  input wire logic rd_n_i,
  input wire logic wr_n_i,
  input wire logic [15:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic [15:0] ad_oe_i,
  input wire logic [3:0] dly_i,
  input wire logic pol_i,
  output logic [15:0] rdata_o,
  output logic ready_o
);
  logic [15:0] mem [256];
  logic [7:0] a;
  logic [15:0] last = 16'h0;
  logic [3:0] cnt = 4'h0;
  always @(posedge clk_i) begin
    if (ale_i) a <= (|ad_oe_i) ? wdata_i[7:0] : addr_i[7:0];
    if (!wr_n_i) mem[a] <= wdata_i;
    if (!rd_n_i) last <= mem[a];
    cnt <= (rd_n_i && wr_n_i) ? 4'h0 : cnt + 4'(cnt != 4'hf);
  end
  // Released lines show the inverse of the last value
  assign rdata_o = !rd_n_i ? mem[a] : ~last;
  assign ready_o = (cnt >= dly_i) ? pol_i : !pol_i;
endmodule : ebu_mem_model

// ===== test/tb_external_bus_controller.sv
// Bench for the external bus unit: CPU accesses through one task.
// Assumes ebu_mem_model on the pins and ebu_asserts bound below.
`timescale 1ns/1ps
module tb_external_bus_controller;
  import ebu_pkg::*;
  logic sys_clk_i, rst_n_i, ack_o, err_o, ext_en_i, arb_en_i, slave_i, reference_clock_output_o, bus_oe_o;
  logic ale_o, rd_n_o, wr_n_o, ready_i, hold_n_i, bus_claim_out_n_o, grant_acknowledge_n_o, grant_acknowledge_oe_o, low_byte_data_lines;
  logic [15:0] rdata_o, addr_o, ad_o, ad_oe_o, ad_i, mem_q, lx_rdata_i, d;
  logic [7:0] seg_o, seg_seen;
  logic [4:0] cs_n_o, cs_seen;
  logic [3:0] seg_cnt_i, dly;
  logic err_seen, claim_seen = 1'h0;
  ebu_req_t req_i, lx_req_o;
  ebu_wcfg_t win_cfg_i [NWIN];
  ebu_rcfg_t reg_cfg_i [NREG];
  int num_errors = 0, n_tests = 0, rd_low, cyc = 0;
  logic [23:0] ta [5] = '{24'h3f0010, 24'h010020, 24'h011050, 24'h020030, 24'h021040};
  logic [4:0] tc [5] = '{5'h1e, 5'h1b, 5'h1d, 5'h0f, 5'h17};
  logic [15:0] tm [5] = '{16'hffff, 16'hffff, 16'hffff, 16'h00ff, 16'h00ff};
  wire logic grant_acknowledge_n_i = grant_acknowledge_oe_o ? grant_acknowledge_n_o : bus_claim_out_n_o;
  wire logic lx_ready_i = lx_req_o.req;
  assign ad_i = (ad_o & ad_oe_o) | (mem_q & ~ad_oe_o);
  ebu_top u_dut (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .req_i(req_i), .ack_o(ack_o),
    .err_o(err_o), .rdata_o(rdata_o), .ext_en_i(ext_en_i), .seg_cnt_i(seg_cnt_i),
    .win_cfg_i(win_cfg_i), .reg_cfg_i(reg_cfg_i), .arb_en_i(arb_en_i), .slave_i(slave_i),
    .reference_clock_output_o(reference_clock_output_o), .bus_oe_o(bus_oe_o), .addr_o(addr_o), .seg_o(seg_o), .ad_o(ad_o),
    .ad_oe_o(ad_oe_o), .ad_i(ad_i), .cs_n_o(cs_n_o), .ale_o(ale_o), .rd_n_o(rd_n_o),
    .wr_n_o(wr_n_o), .ready_i(ready_i), .hold_n_i(hold_n_i), .bus_claim_out_n_o(bus_claim_out_n_o),
    .grant_acknowledge_n_o(grant_acknowledge_n_o), .grant_acknowledge_oe_o(grant_acknowledge_oe_o), .grant_acknowledge_n_i(grant_acknowledge_n_i), .lx_req_o(lx_req_o),
    .lx_rdata_i(lx_rdata_i), .lx_ready_i(lx_ready_i));
  ebu_mem_model u_mem (.clk_i(sys_clk_i), .ale_i(ale_o), .rd_n_i(rd_n_o), .wr_n_i(wr_n_o),
    .addr_i(addr_o), .wdata_i(ad_o), .ad_oe_i(ad_oe_o), .dly_i(dly), .pol_i(low_byte_data_lines),
    .rdata_o(mem_q), .ready_o(ready_i));
  initial begin
    sys_clk_i = 1'h0;
    forever #2.5 sys_clk_i = ~sys_clk_i;
  end
  always @(posedge sys_clk_i) begin
    if (cs_n_o !== 5'h1f) begin
      cs_seen <= cs_n_o;
      seg_seen <= seg_o;
    end
    if (err_o) err_seen <= 1'h1;
    if (!rd_n_o) rd_low <= rd_low + 1;
    if (!bus_claim_out_n_o) claim_seen <= 1'h1;
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors++;
      end_of_test();
    end
  end
  function automatic ebu_rcfg_t mk(input logic [1:0] m, input logic r);
    return '{m, r, 1'h0, 1'h1, 2'h0, 4'h3};
  endfunction : mk
  task automatic chk(input string nm, input logic [15:0] s, input logic [15:0] e);
    n_tests++;
    if (s !== e) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic acc(input logic w, input logic [23:0] a, input logic [15:0] wd);
    int n;
    n = 0;
    cs_seen = 5'h1f;
    err_seen = 1'h0;
    rd_low = 0;
    req_i <= '{1'h1, w, a, wd};
    while (ack_o !== 1'h1 && n < 300) begin
      @(posedge sys_clk_i);
      #1;
      n++;
    end
    @(negedge sys_clk_i);
    req_i.req <= 1'h0;
    // Let the acknowledge fall and the request stay low for a cycle before the next call
    @(negedge sys_clk_i);
  endtask : acc
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : end_of_test
  initial begin
    rst_n_i = 1'h0;
    req_i = '0;
    {ext_en_i, arb_en_i, slave_i, hold_n_i, low_byte_data_lines} = 5'h13;
    {seg_cnt_i, dly, lx_rdata_i} = {4'h4, 4'h0, 16'h5a5a};
    reg_cfg_i = '{mk(MODE_DMX16, 1'h0), mk(MODE_DMX16, 1'h0), mk(MODE_MUX16, 1'h0),
      mk(MODE_DMX8, 1'h0), mk(MODE_MUX8, 1'h0)};
    win_cfg_i = '{'{1'h1, 12'h010, 12'hff0}, '{1'h1, 12'h010, 12'hfff},
      '{1'h1, 12'h020, 12'hff0}, '{1'h1, 12'h020, 12'hfff}};
    repeat (20) @(negedge sys_clk_i);
    rst_n_i = 1'h1;
    for (int i = 0; i < 5; i++) begin
      d = {ta[i][7:0], ~ta[i][7:0]};
      acc(1'h1, ta[i], d);
      acc(1'h0, ta[i], 16'h0);
      chk("rdata", rdata_o, d & tm[i]);
      chk("select", 16'(cs_seen), 16'(tc[i]));
      chk("segment", 16'(seg_seen), 16'(ta[i][23:16] & 8'h0f));
    end
    $display("test windows done");
    reg_cfg_i[0] = '{MODE_DMX16, 1'h1, 1'h0, 1'h1, 2'h0, 4'h3};
    {low_byte_data_lines, dly} = 5'h0c;
    acc(1'h0, ta[0], 16'h0);
    chk("ready data", rdata_o, 16'h10ef);
    chk("stretch", 16'(rd_low > 12), 16'h1);
    reg_cfg_i[0] = mk(MODE_DMX16, 1'h0);
    $display("test ready done");
    ext_en_i = 1'h0;
    acc(1'h0, ta[0], 16'h0);
    chk("refused", 16'({err_seen, cs_seen}), 16'h3f);
    acc(1'h0, 24'h200010, 16'h0);
    chk("internal", rdata_o, 16'h5a5a);
    chk("internal err", 16'(err_seen), 16'h0);
    ext_en_i = 1'h1;
    $display("test single chip done");
    {arb_en_i, hold_n_i} = 2'h2;
    for (int n = 0; n < 50 && grant_acknowledge_n_o !== 1'h0; n++) @(negedge sys_clk_i);
    chk("grant", 16'({grant_acknowledge_n_o, bus_oe_o}), 16'h0);
    hold_n_i = 1'h1;
    slave_i = 1'h1;
    acc(1'h1, ta[0], 16'h7e81);
    acc(1'h0, ta[0], 16'h0);
    chk("slave", rdata_o, 16'h7e81);
    chk("claim", 16'(claim_seen), 16'h1);
    slave_i = 1'h0;
    $display("test arbitration done");
    end_of_test();
  end
endmodule : tb_external_bus_controller
bind ebu_top ebu_asserts u_chk (.sys_clk_i, .rst_n_i, .ack_o, .err_o, .seg_cnt_i, .arb_en_i,
  .slave_i, .reference_clock_output_o, .bus_oe_o, .seg_o, .ad_oe_o, .cs_n_o, .ale_o, .rd_n_o, .wr_n_o,
  .bus_claim_out_n_o, .grant_acknowledge_n_o, .grant_acknowledge_oe_o);
